// [inc/smc_map.svh]
/*
 Register offsets, field positions, reset values and event widths of the
 serial port mode control block. Assumes 32-bit APB word addressing.
*/
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
`define SMC_MODE_OFFSET 12'h000
`define SMC_STATUS_OFFSET 12'h004
`define SMC_MASK_OFFSET 12'h008
`define SMC_STATE_OFFSET 12'h00c
`define SMC_ENABLE_BIT 15
`define SMC_IDLE_STOP_BIT 13
`define SMC_CODEC_BIT 12
`define SMC_RTS_MODE_BIT 11
`define SMC_PIN_USE_LSB 8
`define SMC_WAKE_BIT 7
`define SMC_LOOP_BIT 6
`define SMC_AUTO_BIT 5
`define SMC_RX_INV_BIT 4
`define SMC_HIGH_SPEED_BIT 3
`define SMC_PARITY_LSB 1
`define SMC_STOP_BIT 0
`define SMC_MODE_WMASK 16'hbbff
`define SMC_MODE_RESET 16'h0000
`define SMC_EVT_WAKE_BIT 0
`define SMC_EVT_AUTO_BIT 1
`define SMC_EVT_WIDTH 2
`define SMC_SYNC_CHAR 8'h55
`endif

// [inc/smc_pkg.sv]
/*
 Types of the serial port mode control block.
 Assumes inc/smc_map.svh is on the include path.
*/
`default_nettype none
package smc_pkg;
   typedef enum logic [1:0] {
      SMC_PINS_TXRX,
      SMC_PINS_RTS,
      SMC_PINS_RTS_CTS,
      SMC_PINS_BCLK
   } smc_pin_use_type;
   typedef struct packed {
      logic serial_port_enable;
      logic idle_stop;
      logic infrared_codec_enable;
      logic request_pin_mode;
      smc_pin_use_type pin_usage_select;
      logic wake_enable;
      logic loop_back_enable;
      logic auto_rate_detect;
      logic receive_idle_invert;
      logic high_speed_rate_select;
      logic [1:0] parity_data_select;
      logic stop_bit_select;
   } smc_mode_type;
   typedef struct packed {
      logic tx_own;
      logic rx_own;
      logic rts_own;
      logic cts_own;
      logic bclk_own;
   } smc_pin_own_type;
endpackage : smc_pkg
`default_nettype wire

// [hdl/smc_wake_detect.sv]
/*
 Receive-pin edge watcher for wake from sleep.
 Assumes the receive pin is synchronous to clk_sys.
*/
`default_nettype none
module smc_wake_detect
   import smc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic rx_level,
   output logic fall_edge,
   output logic rise_edge
);
   typedef struct packed {
      logic last;
   } smc_wd_state_type;
   smc_wd_state_type st;
   smc_wd_state_type next_st;
   always_comb begin
      next_st = st;
      next_st.last = rx_level;
      fall_edge = st.last & ~rx_level;
      rise_edge = ~st.last & rx_level;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '{last: 1'b1};
      end else begin
         st <= next_st;
      end
   end
endmodule : smc_wake_detect
`default_nettype wire

// [hdl/smc_mode_control.sv]
/*
 Serial port mode register with APB slave, pin ownership, wake and
 auto-rate bookkeeping, and interrupt status/mask.
 Assumes receive pin and datapath strobes are synchronous to clk_sys.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
// Notes on behaviour
// - Enable hands pins to port per usage
// - Disable returns pins, gates module power
// - Idle-stop halts module during idle
// - Codec bit inserts infrared encoder/decoder
// - Request pin mode: simplex or flow control
// - Usage field selects owned pins
// - Wake: interrupt on fall, clear on rise
// - Loopback routes transmit into receiver
// - Auto-rate measures sync, hardware clears bit
// - Bits 14 and 10 read zero
`default_nettype none
`include "smc_map.svh"
module smc_mode_control
   import smc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic device_idle,
   input wire logic device_sleep,
   input wire logic receive_pin,
   input wire logic tx_serial,
   input wire logic auto_rate_done,
   output logic module_run,
   output logic codec_insert,
   output logic rts_simplex,
   output smc_pin_own_type pin_own,
   output logic rx_to_receiver,
   output logic tx_to_pin,
   output logic irq
);
   typedef struct packed {
      smc_mode_type mode;
      logic [`SMC_EVT_WIDTH-1:0] status;
      logic [`SMC_EVT_WIDTH-1:0] mask;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic run;
      logic codec;
      logic simplex;
      smc_pin_own_type own;
      logic rx_path;
      logic tx_path;
      logic irq;
   } smc_state_type;

   smc_state_type st;
   smc_state_type next_st;
   logic fall_edge;
   logic rise_edge;

   function automatic smc_pin_own_type pin_map(input logic en, input smc_pin_use_type use_sel);
      smc_pin_own_type o;
      o = '0;
      // Ownership only while the port is enabled
      if (en) begin
         o.tx_own = 1'b1;
         o.rx_own = 1'b1;
         case (use_sel)
            SMC_PINS_TXRX: o = o;
            SMC_PINS_RTS: o.rts_own = 1'b1;
            SMC_PINS_RTS_CTS: begin
               o.rts_own = 1'b1;
               o.cts_own = 1'b1;
            end
            SMC_PINS_BCLK: o.bclk_own = 1'b1;
            default: o = o;
         endcase
      end
      return o;
   endfunction : pin_map

   function automatic logic [15:0] mode_word(input smc_mode_type m);
      logic [15:0] w;
      // Packs the stored mode into its register layout
      w = 16'h0000;
      w[`SMC_ENABLE_BIT] = m.serial_port_enable;
      w[`SMC_IDLE_STOP_BIT] = m.idle_stop;
      w[`SMC_CODEC_BIT] = m.infrared_codec_enable;
      w[`SMC_RTS_MODE_BIT] = m.request_pin_mode;
      w[`SMC_PIN_USE_LSB+:2] = m.pin_usage_select;
      w[`SMC_WAKE_BIT] = m.wake_enable;
      w[`SMC_LOOP_BIT] = m.loop_back_enable;
      w[`SMC_AUTO_BIT] = m.auto_rate_detect;
      w[`SMC_RX_INV_BIT] = m.receive_idle_invert;
      w[`SMC_HIGH_SPEED_BIT] = m.high_speed_rate_select;
      w[`SMC_PARITY_LSB+:2] = m.parity_data_select;
      w[`SMC_STOP_BIT] = m.stop_bit_select;
      return w;
   endfunction : mode_word

   smc_wake_detect u_wake (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .rx_level(receive_pin),
      .fall_edge(fall_edge),
      .rise_edge(rise_edge)
   );

   always_comb begin
      logic wr;
      logic rd;
      logic [15:0] wv;
      logic [`SMC_EVT_WIDTH-1:0] evt;
      logic [`SMC_EVT_WIDTH-1:0] clr;
      logic wake_hit;
      logic auto_hit;
      wr = 1'b0;
      rd = 1'b0;
      wv = 16'h0000;
      evt = '0;
      clr = '0;
      wake_hit = 1'b0;
      auto_hit = 1'b0;
      next_st = st;
      // Reads answer from the setup edge; writes land at the access edge
      wr = psel & penable & pwrite & st.ready;
      rd = psel & ~penable & ~pwrite;
      wv = pwdata[15:0] & `SMC_MODE_WMASK;
      next_st.ready = psel & ~penable;
      next_st.err = 1'b0;
      if (psel & ~penable) begin
         next_st.err = (paddr != `SMC_MODE_OFFSET) && (paddr != `SMC_STATUS_OFFSET) &&
            (paddr != `SMC_MASK_OFFSET) && (paddr != `SMC_STATE_OFFSET);
      end

      // Read data stands with the ready pulse
      if (rd) begin
         case (paddr)
            `SMC_MODE_OFFSET: next_st.rdata = {16'h0000, mode_word(st.mode)};
            `SMC_STATUS_OFFSET: next_st.rdata = {30'h0, st.status};
            `SMC_MASK_OFFSET: next_st.rdata = {30'h0, st.mask};
            `SMC_STATE_OFFSET: next_st.rdata = {27'h0, st.own};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end

      // Reserved bits are masked off before any mode write
      if (wr) begin
         case (paddr)
            `SMC_MODE_OFFSET: begin
               next_st.mode.serial_port_enable = wv[`SMC_ENABLE_BIT];
               next_st.mode.idle_stop = wv[`SMC_IDLE_STOP_BIT];
               next_st.mode.infrared_codec_enable = wv[`SMC_CODEC_BIT];
               next_st.mode.request_pin_mode = wv[`SMC_RTS_MODE_BIT];
               next_st.mode.pin_usage_select = smc_pin_use_type'(wv[`SMC_PIN_USE_LSB+:2]);
               next_st.mode.wake_enable = wv[`SMC_WAKE_BIT];
               next_st.mode.loop_back_enable = wv[`SMC_LOOP_BIT];
               next_st.mode.auto_rate_detect = wv[`SMC_AUTO_BIT];
               next_st.mode.receive_idle_invert = wv[`SMC_RX_INV_BIT];
               next_st.mode.high_speed_rate_select = wv[`SMC_HIGH_SPEED_BIT];
               next_st.mode.parity_data_select = wv[`SMC_PARITY_LSB+:2];
               next_st.mode.stop_bit_select = wv[`SMC_STOP_BIT];
            end
            `SMC_STATUS_OFFSET: clr = pwdata[`SMC_EVT_WIDTH-1:0];
            `SMC_MASK_OFFSET: next_st.mask = pwdata[`SMC_EVT_WIDTH-1:0];
            default: next_st.mask = next_st.mask;
         endcase
      end

      // Wake bit watches the pin only while sleeping
      wake_hit = st.mode.wake_enable & device_sleep & st.mode.serial_port_enable;
      if (wake_hit & rise_edge & st.status[`SMC_EVT_WAKE_BIT]) begin
         next_st.mode.wake_enable = 1'b0;
      end
      evt[`SMC_EVT_WAKE_BIT] = wake_hit & fall_edge;

      // Measuring logic reports the sync character done; hardware clear wins
      auto_hit = st.mode.auto_rate_detect & auto_rate_done;
      if (auto_hit) begin
         next_st.mode.auto_rate_detect = 1'b0;
      end
      evt[`SMC_EVT_AUTO_BIT] = auto_hit;

      // Set wins over a same-cycle clear
      next_st.status = (st.status & ~clr) | evt;
      next_st.irq = |(next_st.status & next_st.mask);

      // Derived outputs follow the next mode, in step with the stored mode
      next_st.run = next_st.mode.serial_port_enable &
         ~(next_st.mode.idle_stop & device_idle);
      next_st.codec = next_st.mode.infrared_codec_enable & next_st.run;
      next_st.simplex = next_st.mode.request_pin_mode;
      next_st.own = pin_map(next_st.mode.serial_port_enable,
         next_st.mode.pin_usage_select);
      next_st.rx_path = next_st.mode.loop_back_enable ? tx_serial : receive_pin;
      next_st.tx_path = ~next_st.mode.loop_back_enable;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
   assign module_run = st.run;
   assign codec_insert = st.codec;
   assign rts_simplex = st.simplex;
   assign pin_own = st.own;
   assign rx_to_receiver = st.rx_path;
   assign tx_to_pin = st.tx_path;
   assign irq = st.irq;

   // Pin ownership and run state follow the stored mode in the same clock
   AST_ENABLE_PINS: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(st.mode.serial_port_enable) |-> pin_own.tx_own && pin_own.rx_own)
      else $error("pins not taken on enable");
   AST_RUN_ENABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
      module_run |-> st.mode.serial_port_enable)
      else $error("module runs while disabled");
   AST_DISABLE_PINS: assert property (@(posedge clk_sys) disable iff (!nrst)
      !st.mode.serial_port_enable |-> pin_own == '0 && !module_run)
      else $error("pins held while disabled");
   AST_IDLE_STOP: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.idle_stop && $past(device_idle) |-> !module_run)
      else $error("module runs in idle");
   AST_CODEC: assert property (@(posedge clk_sys) disable iff (!nrst)
      codec_insert |-> st.mode.infrared_codec_enable)
      else $error("codec inserted while off");
   AST_RTS_MODE: assert property (@(posedge clk_sys) disable iff (!nrst)
      rts_simplex == st.mode.request_pin_mode)
      else $error("request pin mode wrong");
   AST_BCLK_NO_CTS: assert property (@(posedge clk_sys) disable iff (!nrst)
      pin_own.bclk_own |-> !pin_own.cts_own && !pin_own.rts_own)
      else $error("baud clock mode owns handshake pins");
   AST_RTS_OWN: assert property (@(posedge clk_sys) disable iff (!nrst)
      pin_own.rts_own |-> st.mode.pin_usage_select == SMC_PINS_RTS ||
      st.mode.pin_usage_select == SMC_PINS_RTS_CTS)
      else $error("request pin owned in wrong usage");
   AST_CTS_OWN: assert property (@(posedge clk_sys) disable iff (!nrst)
      pin_own.cts_own |-> st.mode.pin_usage_select == SMC_PINS_RTS_CTS)
      else $error("clear pin owned in wrong usage");

   // Wake: event on a fall while asleep, bit dropped on the next rise
   AST_WAKE_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.wake_enable && st.mode.serial_port_enable && device_sleep && fall_edge
      |=> st.status[`SMC_EVT_WAKE_BIT])
      else $error("wake event lost");
   AST_WAKE_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.wake_enable && st.mode.serial_port_enable && device_sleep && rise_edge &&
      st.status[`SMC_EVT_WAKE_BIT] |=> !st.mode.wake_enable)
      else $error("wake bit not cleared on rise");
   AST_STATUS_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.status[`SMC_EVT_WAKE_BIT] &&
      !(psel && penable && pwrite && pready && paddr == `SMC_STATUS_OFFSET)
      |=> st.status[`SMC_EVT_WAKE_BIT])
      else $error("wake status lost");
   AST_LOOP: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.loop_back_enable && $stable(st.mode.loop_back_enable)
      |-> rx_to_receiver == $past(tx_serial) && !tx_to_pin)
      else $error("loopback not routed");
   AST_TX_PATH: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(nrst) |-> tx_to_pin == !st.mode.loop_back_enable)
      else $error("transmit path wrong");
   AST_AUTO_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.auto_rate_detect && auto_rate_done
      |=> !st.mode.auto_rate_detect ##0 st.status[`SMC_EVT_AUTO_BIT])
      else $error("auto rate bit not cleared");
   AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!nrst)
      pready && st.rdata[16] == 1'b0 |-> prdata[14] == 1'b0 && prdata[10] == 1'b0)
      else $error("reserved bits read nonzero");

   // Bus answer: one ready pulse per setup, error only with ready
   AST_READY_ANSWER: assert property (@(posedge clk_sys) disable iff (!nrst)
      psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
      pready |=> !pready)
      else $error("ready held too long");
   AST_SLVERR_QUAL: assert property (@(posedge clk_sys) disable iff (!nrst)
      pslverr |-> pready)
      else $error("error without ready");

   // Main scenarios
   COV_WAKE: cover property (@(posedge clk_sys) disable iff (!nrst)
      $fell(st.mode.wake_enable));
   COV_AUTO: cover property (@(posedge clk_sys) disable iff (!nrst)
      $fell(st.mode.auto_rate_detect));
   COV_IRQ: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(irq));
   COV_BCLK: cover property (@(posedge clk_sys) disable iff (!nrst) pin_own.bclk_own);
   COV_IDLE: cover property (@(posedge clk_sys) disable iff (!nrst)
      st.mode.idle_stop && device_idle && st.mode.serial_port_enable);
endmodule : smc_mode_control
`default_nettype wire

// [tb/smc_remote_model.sv]
/*
 Remote serial device on the receive pin: sends one frame on request.
 Assumes the line idles high and bits go out least significant first.
*/
`default_nettype none
module smc_remote_model #(
   parameter int BIT_CYCLES = 4
) (
   input wire logic clk_sys,
   input wire logic send,
   input wire logic [7:0] tx_byte,
   output logic receive_pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      logic [9:0] frame;
      receive_pin = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (send) begin
            busy <= 1'b1;
            frame = {1'b1, tx_byte, 1'b0};
            for (int i = 0; i < 10; i++) begin
               receive_pin <= frame[i];
               repeat (BIT_CYCLES) @(posedge clk_sys);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule : smc_remote_model
`default_nettype wire

// [tb/tb.sv]
/*
 Self-checking bench of the mode control block over APB.
 Assumes the design files, smc_map.svh and the remote model compile first.
*/
`default_nettype none
`include "smc_map.svh"
module tb;
   import smc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq, rd_err;
   logic device_idle, device_sleep, tx_serial, auto_rate_done, send, receive_pin, busy;
   logic module_run, codec_insert, rts_simplex, rx_to_receiver, tx_to_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   smc_pin_own_type pin_own;
   int errors, check_count;
   smc_mode_control smc_mode_control_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .device_idle(device_idle),
      .device_sleep(device_sleep), .receive_pin(receive_pin), .tx_serial(tx_serial),
      .auto_rate_done(auto_rate_done), .module_run(module_run), .codec_insert(codec_insert),
      .rts_simplex(rts_simplex), .pin_own(pin_own), .rx_to_receiver(rx_to_receiver),
      .tx_to_pin(tx_to_pin), .irq(irq));
   smc_remote_model #(.BIT_CYCLES(4)) smc_remote_model_inst (.clk_sys(clk_sys),
      .send(send), .tx_byte(8'h55), .receive_pin(receive_pin), .busy(busy));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         chk("pready", 1, 0);
         test_done();
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd_data);
   endtask : rd
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_n
   task automatic t_reset_access();
      rd("mode", `SMC_MODE_OFFSET, 32'h0);
      rd("status", `SMC_STATUS_OFFSET, 32'h0);
      rd("mask", `SMC_MASK_OFFSET, 32'h0);
      apb(1'b1, `SMC_MODE_OFFSET, 32'hffff4ff7);
      rd("mode", `SMC_MODE_OFFSET, 32'h00000bf7);
      apb(1'b1, `SMC_MODE_OFFSET, 32'h0);
      rd("bad", 12'h010, 32'h0);
      chk("pslverr", 1, rd_err);
   endtask : t_reset_access
   task automatic t_pins();
      logic [4:0] own_exp [4] = '{5'h18, 5'h1c, 5'h1e, 5'h19};
      for (int u = 0; u < 4; u++) begin
         apb(1'b1, `SMC_MODE_OFFSET, 32'h8000 | (u << 8));
         wait_n(2);
         chk("pin_own", 32'(own_exp[u]), 32'(pin_own));
         rd("pin_state", `SMC_STATE_OFFSET, 32'(own_exp[u]));
      end
      apb(1'b1, `SMC_MODE_OFFSET, 32'h0);
      wait_n(2);
      chk("pin_own", 0, 32'(pin_own));
      chk("module_run", 0, 32'(module_run));
   endtask : t_pins
   task automatic t_controls();
      apb(1'b1, `SMC_MODE_OFFSET, 32'hb940);
      tx_serial <= 1'b0;
      wait_n(2);
      chk("module_run", 1, 32'(module_run));
      chk("codec_insert", 1, 32'(codec_insert));
      chk("rts_simplex", 1, 32'(rts_simplex));
      chk("tx_to_pin", 0, 32'(tx_to_pin));
      chk("rx_to_receiver", 0, 32'(rx_to_receiver));
      tx_serial <= 1'b1;
      device_idle <= 1'b1;
      wait_n(2);
      chk("rx_to_receiver", 1, 32'(rx_to_receiver));
      chk("module_run", 0, 32'(module_run));
      apb(1'b1, `SMC_MODE_OFFSET, 32'h8000);
      tx_serial <= 1'b0;
      wait_n(2);
      chk("module_run", 1, 32'(module_run));
      chk("codec_insert", 0, 32'(codec_insert));
      chk("rts_simplex", 0, 32'(rts_simplex));
      chk("rx_to_receiver", 1, 32'(rx_to_receiver));
      chk("tx_to_pin", 1, 32'(tx_to_pin));
      device_idle <= 1'b0;
   endtask : t_controls
   task automatic t_wake_auto();
      int n;
      apb(1'b1, `SMC_MASK_OFFSET, 32'h0);
      apb(1'b1, `SMC_MODE_OFFSET, 32'h80a0);
      device_sleep <= 1'b1;
      send <= 1'b1;
      @(posedge clk_sys);
      send <= 1'b0;
      for (n = 0; n < 50; n++) begin
         apb(1'b0, `SMC_STATUS_OFFSET, 32'h0);
         if (rd_data[0] === 1'b1) break;
      end
      chk("status", 1, rd_data);
      chk("irq", 0, 32'(irq));
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk_sys);
      chk("busy", 0, 32'(busy));
      rd("mode", `SMC_MODE_OFFSET, 32'h8020);
      auto_rate_done <= 1'b1;
      @(posedge clk_sys);
      auto_rate_done <= 1'b0;
      rd("mode", `SMC_MODE_OFFSET, 32'h8000);
      rd("status", `SMC_STATUS_OFFSET, 32'h3);
      apb(1'b1, `SMC_MASK_OFFSET, 32'h3);
      wait_n(2);
      chk("irq", 1, 32'(irq));
      apb(1'b1, `SMC_STATUS_OFFSET, 32'h1);
      rd("status", `SMC_STATUS_OFFSET, 32'h2);
      apb(1'b1, `SMC_STATUS_OFFSET, 32'h2);
      wait_n(2);
      chk("irq", 0, 32'(irq));
      device_sleep <= 1'b0;
   endtask : t_wake_auto
   task automatic t_mid_reset();
      apb(1'b1, `SMC_MODE_OFFSET, 32'h9a5b);
      apb(1'b1, `SMC_MASK_OFFSET, 32'h3);
      rd("mode", `SMC_MODE_OFFSET, 32'h9a5b);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("pin_own", 0, 32'(pin_own));
      nrst <= 1'b1;
      rd("mode", `SMC_MODE_OFFSET, 32'h0);
      rd("mask", `SMC_MASK_OFFSET, 32'h0);
   endtask : t_mid_reset
   initial begin
      {nrst, psel, penable, pwrite, device_idle, device_sleep} = 6'h00;
      {tx_serial, auto_rate_done, send} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      errors = 0;
      check_count = 0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset_access();
      t_pins();
      t_controls();
      t_wake_auto();
      t_mid_reset();
      test_done();
   end
endmodule : tb
`default_nettype wire
